// ---- pkg/paoc_pkg.sv ----
// Constants and types shared by the converter output control block
package paoc_pkg;
    localparam int CODE_W = 14;
    localparam int PIPE_DEPTH = 5;
    localparam int ADDR_W = 4;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_DATA = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 4'hC;
    // Mask sits beyond the 4-bit window low bits; use a wider compare
    localparam logic [4:0] OFS_INT_MASK = 5'h10;
    // Field positions
    localparam int CTRL_CONV_EN = 0;
    localparam int EV_WORD = 0;
    localparam int EV_RANGE = 1;
    localparam int EV_LOCK = 2;
    localparam int EV_W = 3;
    localparam int ST_TWOS = 2;
    localparam int ST_STAB = 3;
    localparam int ST_LOCK = 4;
    localparam int ST_DRIVE = 5;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    // Timing
    localparam int CLK_MHZ = 40;
    localparam int STOP_NS = 2000;
    localparam int STOP_CYC = (STOP_NS * CLK_MHZ) / 1000;
    localparam int LOCK_EDGES = 100;
    localparam int PER_W = 12;

    typedef enum logic [1:0] {
        PS_NORMAL = 2'b00,
        PS_HIZ = 2'b01,
        PS_NAP = 2'b10,
        PS_SLEEP = 2'b11
    } paoc_power_t;

    // Four-level format pin, coded low to high
    typedef enum logic [1:0] {
        MODE_GND = 2'b00,
        MODE_THIRD = 2'b01,
        MODE_TWO_THIRDS = 2'b10,
        MODE_FULL = 2'b11
    } paoc_mode_t;

    typedef struct packed {
        logic over;
        logic [CODE_W-1:0] code;
    } paoc_word_t;
endpackage

// ---- verilog/paoc_top.sv ----
// Pipelined converter output control: sampling, latency, format, power
`timescale 1ns/10ps
module paoc_top #(
    parameter int LOCK_COUNT = paoc_pkg::LOCK_EDGES,
    parameter int STOP_COUNT = paoc_pkg::STOP_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic convClock,
    input wire logic powerDownSelect,
    input wire logic outEnableN,
    input wire logic [1:0] formatLevel,
    input wire paoc_pkg::paoc_word_t frontEnd,
    output paoc_pkg::paoc_word_t busWord,
    output logic [paoc_pkg::CODE_W-1:0] sampleBits,
    output logic sampleBitsOe,
    output logic rangeExceededFlag,
    output logic rangeExceededOe,
    output logic holdPhase,
    output paoc_pkg::paoc_power_t powerState,
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    output logic irq
);
    import paoc_pkg::*;

    function automatic logic stabFromMode(input logic [1:0] m);
        stabFromMode = (m == MODE_THIRD) || (m == MODE_TWO_THIRDS);
    endfunction

    function automatic logic twosFromMode(input logic [1:0] m);
        twosFromMode = (m == MODE_TWO_THIRDS) || (m == MODE_FULL);
    endfunction

    // Pin synchronisers; first stage feeds only the second
    logic [1:0] clkSync_q, pdSync_q, oeSync_q;
    logic [1:0] modeSync1_q, modeSync2_q;
    paoc_word_t feSync1_q, feSync2_q;
    logic clkPrev_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            clkSync_q <= 2'h0;
            pdSync_q <= 2'h0;
            oeSync_q <= 2'h3;
            modeSync1_q <= 2'h0;
            modeSync2_q <= 2'h0;
            feSync1_q <= '0;
            feSync2_q <= '0;
            clkPrev_q <= 1'b0;
        end else begin
            clkSync_q <= {clkSync_q[0], convClock};
            pdSync_q <= {pdSync_q[0], powerDownSelect};
            oeSync_q <= {oeSync_q[0], outEnableN};
            modeSync1_q <= formatLevel;
            modeSync2_q <= modeSync1_q;
            feSync1_q <= frontEnd;
            feSync2_q <= feSync1_q;
            clkPrev_q <= clkSync_q[1];
        end
    end

    logic pdS, oeNS, stabOn, twosOn, clkRise;
    assign pdS = pdSync_q[1];
    assign oeNS = oeSync_q[1];
    assign stabOn = stabFromMode(modeSync2_q);
    assign twosOn = twosFromMode(modeSync2_q);
    // Only the rising edge is used; the falling edge never starts work
    assign clkRise = clkSync_q[1] & ~clkPrev_q;

    // Power state straight from the two static pins
    always_comb begin
        if (!pdS && !oeNS) begin
            powerState = PS_NORMAL;
        end else if (!pdS) begin
            powerState = PS_HIZ;
        end else if (!oeNS) begin
            powerState = PS_NAP;
        end else begin
            powerState = PS_SLEEP;
        end
    end

    logic [31:0] ctrl_q;
    logic running, convRise;
    assign running = !pdS && ctrl_q[CTRL_CONV_EN];
    assign convRise = clkRise && running;

    // Period measure for the stabilizer; a stopped clock drops lock
    logic [PER_W-1:0] perCnt_q, period_q;
    logic [7:0] edges_q;
    logic locked, stopped;
    assign stopped = perCnt_q >= PER_W'(STOP_COUNT);
    assign locked = edges_q >= 8'(LOCK_COUNT);
    always_ff @(posedge clock) begin
        if (!nrst) begin
            perCnt_q <= '0;
            period_q <= '0;
            edges_q <= 8'h00;
        end else if (clkRise) begin
            perCnt_q <= '0;
            period_q <= perCnt_q;
            if (!locked) begin
                edges_q <= edges_q + 8'h01;
            end
        end else begin
            if (!stopped) begin
                perCnt_q <= perCnt_q + PER_W'(1);
            end else begin
                edges_q <= 8'h00;
            end
        end
    end

    // Hold lasts half a measured period with the stabilizer, else the pin
    always_comb begin
        if (stabOn) begin
            // Count runs 0 to period-1, so round the half up for 50%
            holdPhase = perCnt_q < ((period_q + PER_W'(1)) >> 1);
        end else begin
            holdPhase = clkSync_q[1];
        end
    end

    // Sample held at the rise, then aligned through the stage registers
    paoc_word_t pipe_q [PIPE_DEPTH];
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pipe_q[0] <= '0;
        end else if (convRise) begin
            pipe_q[0] <= feSync2_q;
        end
    end
    genvar gi;
    generate
        for (gi = 1; gi < PIPE_DEPTH; gi++) begin : gStage
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    pipe_q[gi] <= '0;
                end else if (convRise) begin
                    pipe_q[gi] <= pipe_q[gi-1];
                end
            end
        end
    endgenerate

    // Correction and format stage loads the output word
    paoc_word_t out_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            out_q <= '0;
        end else if (convRise) begin
            out_q.over <= pipe_q[PIPE_DEPTH-1].over;
            out_q.code <= pipe_q[PIPE_DEPTH-1].code
                ^ {twosOn, {(CODE_W-1){1'b0}}};
        end
    end

    assign sampleBits = out_q.code;
    assign rangeExceededFlag = out_q.over;
    assign busWord = out_q;
    assign sampleBitsOe = (powerState == PS_NORMAL);
    assign rangeExceededOe = (powerState == PS_NORMAL);

    // Avalon slave: one wait state, writes land when waitrequest is low
    logic ack_q, req;
    logic [EV_W-1:0] intStat_q, intMask_q, events;
    logic lockedPrev_q;
    assign req = avsRead || avsWrite;
    assign avsWaitrequest = req && !ack_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    logic wrDone;
    assign wrDone = avsWrite && ack_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
            intMask_q <= MASK_RST;
        end else if (wrDone) begin
            if (avsAddress == {1'b0, OFS_CTRL}) begin
                ctrl_q <= {31'h0000_0000, avsWritedata[CTRL_CONV_EN]};
            end else if (avsAddress == OFS_INT_MASK) begin
                intMask_q <= avsWritedata[EV_W-1:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            lockedPrev_q <= 1'b0;
        end else begin
            lockedPrev_q <= locked;
        end
    end

    assign events[EV_WORD] = convRise;
    assign events[EV_RANGE] = convRise && pipe_q[PIPE_DEPTH-1].over;
    assign events[EV_LOCK] = locked && !lockedPrev_q;

    // Set beats a same-cycle write-one clear
    logic [EV_W-1:0] clrBits;
    always_comb begin
        clrBits = '0;
        if (wrDone && avsAddress == {1'b0, OFS_INT_STAT}) begin
            clrBits = avsWritedata[EV_W-1:0];
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            intStat_q <= '0;
        end else begin
            intStat_q <= (intStat_q & ~clrBits) | events;
        end
    end
    assign irq = |(intStat_q & intMask_q);

    logic [31:0] statusWord;
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[1:0] = powerState;
        statusWord[ST_TWOS] = twosOn;
        statusWord[ST_STAB] = stabOn;
        statusWord[ST_LOCK] = locked;
        statusWord[ST_DRIVE] = sampleBitsOe;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            avsReaddata <= 32'h0000_0000;
        end else if (avsRead && !ack_q) begin
            if (avsAddress == {1'b0, OFS_CTRL}) begin
                avsReaddata <= ctrl_q;
            end else if (avsAddress == {1'b0, OFS_STATUS}) begin
                avsReaddata <= statusWord;
            end else if (avsAddress == {1'b0, OFS_DATA}) begin
                avsReaddata <= {17'h00000, out_q};
            end else if (avsAddress == {1'b0, OFS_INT_STAT}) begin
                avsReaddata <= {29'h0000_0000, intStat_q};
            end else if (avsAddress == OFS_INT_MASK) begin
                avsReaddata <= {29'h0000_0000, intMask_q};
            end else begin
                avsReaddata <= 32'h0000_0000;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_normal_drives: assert property (
        (!pdS && !oeNS) |-> (sampleBitsOe && rangeExceededOe))
        else $error("outputs not driven in normal mode");
    a_hiz_converts: assert property (
        (!pdS && oeNS && clkRise && ctrl_q[CTRL_CONV_EN])
        |=> (!sampleBitsOe && pipe_q[0] == $past(feSync2_q)))
        else $error("high impedance mode stopped converting");
    a_nap_state: assert property (
        (pdS && !oeNS) |-> (powerState == PS_NAP && !sampleBitsOe))
        else $error("nap mode wrong");
    a_sleep_state: assert property (
        (pdS && oeNS) |-> (powerState == PS_SLEEP && !rangeExceededOe))
        else $error("sleep mode wrong");
    a_pipe_frozen: assert property (
        pdS |=> $stable(out_q))
        else $error("pipeline advanced while powered down");
    a_stage_shift: assert property (
        convRise |=> pipe_q[PIPE_DEPTH-1] == $past(pipe_q[PIPE_DEPTH-2]))
        else $error("stage alignment broken");
    a_format_msb: assert property (
        convRise |=> (sampleBits[CODE_W-1]
            == ($past(pipe_q[PIPE_DEPTH-1].code[CODE_W-1]) ^ $past(twosOn))))
        else $error("output format msb wrong");
    a_range_flag: assert property (
        convRise |=> rangeExceededFlag == $past(pipe_q[PIPE_DEPTH-1].over))
        else $error("range flag does not follow sample");
    a_stab_hold: assert property (
        (stabOn && clkRise && !stopped) ##1 (period_q > 12'h002)
        |-> holdPhase)
        else $error("stabilizer hold phase missing");
    a_one_update: assert property (
        !convRise |=> $stable(out_q))
        else $error("output changed without a clock rise");
endmodule

// ---- dv/paoc_capture.sv ----
// Capture-side model: supplies the converter clock and front-end words
`timescale 1ns/10ps
module paoc_capture (
    input wire logic clock,
    input wire logic nrst,
    input wire logic run,
    output logic convClock,
    output paoc_pkg::paoc_word_t frontEnd,
    output int riseCount
);
    import paoc_pkg::*;
    logic [3:0] phase;

    // Word that is presented ahead of rise k+1
    function automatic paoc_word_t wordAt(input int k);
        paoc_word_t w;
        w.code = 14'(k) * 14'h04A3 + 14'h0123;
        w.over = (k % 3 == 0);
        return w;
    endfunction

    always_ff @(posedge clock) begin
        if (!nrst) begin
            riseCount <= 0;
            frontEnd <= '0;
        end else if (run && phase == 4'h0) begin
            riseCount <= riseCount + 1;
        end else if (run && phase == 4'h7) begin
            // Changed mid low phase so it is stable well around the rise
            frontEnd <= wordAt(riseCount);
        end
    end

    always_ff @(posedge clock) begin
        if (!run) begin
            // Clock stands still low between bursts
            phase <= 4'h0;
            convClock <= 1'b0;
        end else begin
            phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
            // Short high phase so the stabilizer's own duty shows
            convClock <= (phase < 4'h3);
        end
    end
endmodule

// ---- dv/test_pipelined_adc_output_control.sv ----
// Self-checking bench for the converter output control block
`timescale 1ns/10ps
module test_pipelined_adc_output_control;
    import paoc_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic run = 1'b0;
    logic powerDownSelect = 1'b0;
    logic outEnableN = 1'b0;
    logic [1:0] formatLevel = 2'h0;
    logic [4:0] avsAddress = 5'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic convClock, sampleBitsOe, rangeExceededFlag, rangeExceededOe;
    logic holdPhase, avsWaitrequest, irq;
    logic [CODE_W-1:0] sampleBits;
    logic [31:0] avsReaddata, rd;
    paoc_word_t frontEnd, busWord;
    paoc_power_t powerState;
    int riseCount;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    always #12.5 clock = ~clock;

    // Short lock and stop counts keep the run brief
    paoc_top #(.LOCK_COUNT(4), .STOP_COUNT(20)) dut (.clock(clock),
        .nrst(nrst), .convClock(convClock),
        .powerDownSelect(powerDownSelect), .outEnableN(outEnableN),
        .formatLevel(formatLevel), .frontEnd(frontEnd), .busWord(busWord),
        .sampleBits(sampleBits), .sampleBitsOe(sampleBitsOe),
        .rangeExceededFlag(rangeExceededFlag),
        .rangeExceededOe(rangeExceededOe), .holdPhase(holdPhase),
        .powerState(powerState), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .irq(irq));

    paoc_capture cap (.clock(clock), .nrst(nrst), .run(run),
        .convClock(convClock), .frontEnd(frontEnd), .riseCount(riseCount));

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] wd);
        @(posedge clock);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= wd;
        do @(posedge clock); while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask

    task automatic waitRises(input int n);
        repeat (n) @(negedge convClock);
        @(negedge clock);
    endtask

    task automatic test_regs();
        bus(1'b0, 5'(OFS_CTRL), 32'h0);
        check("ctrl", rd, CTRL_RST);
        bus(1'b0, OFS_INT_MASK, 32'h0);
        check("mask", rd, 32'(MASK_RST));
        bus(1'b1, 5'h14, 32'hFFFF_FFFF);
        bus(1'b0, 5'h14, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask

    task automatic test_stream(input paoc_mode_t m);
        logic twos;
        logic stab;
        int hi;
        paoc_word_t w;
        twos = (m == MODE_TWO_THIRDS) || (m == MODE_FULL);
        stab = (m == MODE_THIRD) || (m == MODE_TWO_THIRDS);
        hi = 0;
        @(posedge clock);
        formatLevel <= m;
        // Lock time before the output is trusted
        waitRises(12);
        for (int i = 0; i < 4; i++) begin
            waitRises(1);
            w = cap.wordAt(riseCount - 6);
            w.code = w.code ^ {twos, 13'h0};
            check("code", sampleBits, w.code);
            check("flag", rangeExceededFlag, w.over);
            check("drive", sampleBitsOe && rangeExceededOe, 1'b1);
            if (i == 0) begin
                // Word stands until the next rise, long after this read
                bus(1'b0, 5'(OFS_DATA), 32'h0);
                check("data", rd, {17'h00000, w});
            end
        end
        repeat (10) begin
            @(negedge clock);
            hi += int'(holdPhase);
        end
        // Pin is high 3 of 10 cycles; the stabilizer makes it half
        check("hold", hi, stab ? 5 : 3);
        bus(1'b0, 5'(OFS_STATUS), 32'h0);
        check("twos", rd[ST_TWOS], twos);
        check("stab", rd[ST_STAB], stab);
    endtask

    task automatic test_power();
        paoc_word_t held;
        for (int p = 0; p < 4; p++) begin
            @(posedge clock);
            powerDownSelect <= p[1];
            outEnableN <= p[0];
            waitRises(3);
            held = busWord;
            check("state", powerState, p[1:0]);
            check("oe", sampleBitsOe || rangeExceededOe, p == 0);
            waitRises(1);
            if (p[1]) begin
                check("frozen", busWord, held);
            end else begin
                check("busword", busWord, cap.wordAt(riseCount - 6));
            end
        end
        @(posedge clock);
        powerDownSelect <= 1'b0;
        outEnableN <= 1'b0;
        bus(1'b1, 5'(OFS_CTRL), 32'h0);
        waitRises(1);
        held = busWord;
        waitRises(2);
        check("disabled", busWord, held);
        bus(1'b0, 5'(OFS_CTRL), 32'h0);
        check("ctrl off", rd, 32'h0);
        bus(1'b1, 5'(OFS_CTRL), 32'h1);
    endtask

    task automatic test_irq();
        bus(1'b0, 5'(OFS_INT_STAT), 32'h0);
        check("word event", rd[EV_WORD], 1'b1);
        check("range event", rd[EV_RANGE], 1'b1);
        check("lock event", rd[EV_LOCK], 1'b1);
        check("irq masked", irq, 1'b0);
        bus(1'b1, OFS_INT_MASK, 32'h1);
        @(negedge clock);
        check("irq on", irq, 1'b1);
        @(posedge clock);
        run <= 1'b0;
        repeat (30) @(posedge clock);
        bus(1'b1, 5'(OFS_INT_STAT), 32'h7);
        bus(1'b0, 5'(OFS_INT_STAT), 32'h0);
        check("cleared", rd[EV_W-1:0], 3'h0);
        check("irq off", irq, 1'b0);
        // A stopped clock must drop the stabilizer lock
        bus(1'b0, 5'(OFS_STATUS), 32'h0);
        check("unlocked", rd[ST_LOCK], 1'b0);
        @(posedge clock);
        run <= 1'b1;
        waitRises(2);
        check("irq again", irq, 1'b1);
        waitRises(4);
        bus(1'b0, 5'(OFS_INT_STAT), 32'h0);
        check("relock", rd[EV_LOCK], 1'b1);
    endtask

    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        test_regs();
        @(posedge clock);
        run <= 1'b1;
        test_stream(MODE_FULL);
        test_stream(MODE_THIRD);
        test_stream(MODE_TWO_THIRDS);
        test_stream(MODE_GND);
        test_power();
        waitRises(6);
        test_irq();
        give_verdict();
    end
endmodule
